//--- pdma_pkg.sv
package pdma_pkg;
	localparam int addr_width = 18;
	localparam int data_width = 16;
	localparam int count_width = 16;
	// Sequencer states; the numbers are the documented state numbers
	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_grab = 3'h1,
		st_fetch = 3'h2,
		st_bump = 3'h3,
		st_wait_ctl = 3'h4,
		st_taken = 3'h5,
		st_wait_rel = 3'h6,
		st_done = 3'h7
	} seq_state_t;
	localparam logic [addr_width-1:0] addr_step = 18'h00002;
	localparam logic [count_width-1:0] count_step = 16'h0001;
	localparam logic [addr_width-1:0] addr_reset = 18'h00000;
	localparam logic [count_width-1:0] count_reset = 16'h0000;
	// Input-complete trap address, 000120 octal
	localparam logic [data_width-1:0] in_trap_addr = 16'h0050;
	localparam int taken_pulse_ns = 150;
	localparam int clk_period_ns = 20;
	localparam int taken_pulse_cycles = (taken_pulse_ns + clk_period_ns - 1) / clk_period_ns;
	localparam logic [3:0] taken_pulse_len = 4'(taken_pulse_cycles);
	// Leading words of a multi-word input message, in order
	localparam logic [1:0] lead_header = 2'h0;
	localparam logic [1:0] lead_address = 2'h1;
	localparam logic [1:0] lead_count = 2'h2;
	localparam logic [1:0] lead_words = 2'h3;
endpackage : pdma_pkg

//--- pdma_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdma_link_if;
	import pdma_pkg::*;
	logic [data_width-1:0] host_in_data;
	logic host_word_avail;
	logic word_taken_pulse;
	logic host_in_ctl;
	modport dev (output host_in_data, output host_word_avail, output word_taken_pulse,
		input host_in_ctl);
	modport host (input host_in_data, input host_word_avail, input word_taken_pulse,
		output host_in_ctl);
endinterface : pdma_link_if
`default_nettype wire

//--- pdma_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R01) Message opens header, address, then count
// (R02) Leading words use single-word handshake
// (R03) Write-address command loads memory address register
// (R04) Processor supplies top address bits via status
// (R05) Count written as two's complement; nonzero flag
// (R06) Go bit: state 0 to 1, request bus
// (R07) State 2 drives address, routes read data
// (R08) Memory acknowledge raises word-available
// (R09) Leaving state 2: address plus two, count plus one
// (R10) State 4 waits for host control
// (R11) Control: state 5, taken pulse, drop avail
// (R12) State 6 waits for host release
// (R13) Release with count nonzero: back to 1
// (R14) Release with count zero: go to 7
// (R15) State 7 interrupts, returns to idle
// (R16) Host asserts control only when ready
// (R17) Interrupt only when enabled, trap 000120 octal
// (R18) Bus reset idles, releases bus, drops avail
module pdma_dev
	import pdma_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	pdma_link_if.dev link,
	input wire logic [data_width-1:0] proc_data_bus_i,
	input wire logic wr_addr_i,
	input wire logic wr_count_i,
	input wire logic wr_status_i,
	input wire logic wr_data_i,
	input wire logic dma_in_go_i,
	input wire logic ext_addr_lo_bit_i,
	input wire logic ext_addr_hi_bit_i,
	input wire logic in_irq_enable_i,
	input wire logic word_avail_bit_i,
	input wire logic bus_grant_i,
	input wire logic mem_ack_i,
	input wire logic [data_width-1:0] mem_rdata_i,
	input wire logic irq_ack_i,
	output logic bus_req_o,
	output logic mem_rd_o,
	output logic [addr_width-1:0] proc_addr_bus_o,
	output logic count_nonzero_o,
	output logic busy_o,
	output logic irq_o,
	output logic [data_width-1:0] trap_addr_o,
	output logic [2:0] state_o
);
	typedef struct packed {
		seq_state_t st;
		logic [addr_width-1:0] addr;
		logic [count_width-1:0] count;
		logic [data_width-1:0] out_data;
		logic avail;
		logic taken;
		logic [3:0] taken_cnt;
		logic bus_req;
		logic mem_rd;
		logic irq;
		logic irq_en;
		logic dma;
		logic ctl_s1;
		logic ctl_s2;
		logic count_nz;
		logic busy;
		logic [data_width-1:0] trap;
	} dev_state_t;

	dev_state_t r, nxt;

	always_comb begin
		nxt = r;
		nxt.ctl_s1 = link.host_in_ctl;
		nxt.ctl_s2 = r.ctl_s1;
		if (r.irq && irq_ack_i) begin
			nxt.irq = 1'b0;
		end
		// --------------------------------------------------
		// Processor register writes
		// --------------------------------------------------
		if (wr_addr_i) begin
			nxt.addr[data_width-1:0] = proc_data_bus_i; // [R03]
		end
		if (wr_count_i) begin
			nxt.count = proc_data_bus_i; // [R05]
		end
		if (wr_data_i) begin
			nxt.out_data = proc_data_bus_i; // [R02]
		end
		if (wr_status_i) begin
			nxt.addr[addr_width-1:data_width] = {ext_addr_hi_bit_i, ext_addr_lo_bit_i}; // [R04]
			nxt.irq_en = in_irq_enable_i;
			if (r.st == st_idle && dma_in_go_i) begin
				nxt.st = st_grab; // [R06]
				nxt.bus_req = 1'b1; // [R06]
				nxt.dma = 1'b1;
			end else if (r.st == st_idle && word_avail_bit_i) begin
				// Single-word path carries the three leading words
				nxt.avail = 1'b1; // [R01] [R02]
				nxt.dma = 1'b0;
				nxt.st = st_wait_ctl;
			end
		end
		// Pulse length rounds the minimum width up to whole cycles
		if (r.taken_cnt != 4'h0) begin
			nxt.taken_cnt = r.taken_cnt - 4'h1;
			nxt.taken = (r.taken_cnt != 4'h1);
		end
		// --------------------------------------------------
		// Sequencer
		// --------------------------------------------------
		case (r.st)
			st_idle: begin
			end
			st_grab: begin
				// Keep asking until granted; another master may hold the bus
				nxt.bus_req = 1'b1;
				if (bus_grant_i) begin
					nxt.st = st_fetch;
					nxt.mem_rd = 1'b1; // [R07]
				end
			end
			st_fetch: begin
				if (mem_ack_i) begin
					nxt.out_data = mem_rdata_i; // [R07]
					nxt.avail = 1'b1; // [R08]
					nxt.mem_rd = 1'b0;
					nxt.bus_req = 1'b0;
					nxt.st = st_bump;
				end
			end
			st_bump: begin
				nxt.addr = r.addr + addr_step; // [R09]
				nxt.count = r.count + count_step; // [R09]
				nxt.st = st_wait_ctl; // [R10]
			end
			st_wait_ctl: begin
				// Host raises control only once it can take the word
				if (r.ctl_s2) begin // [R10] [R16]
					nxt.st = st_taken; // [R11]
					nxt.taken = 1'b1; // [R11]
					nxt.taken_cnt = taken_pulse_len; // [R11]
					nxt.avail = 1'b0; // [R11]
				end
			end
			st_taken: begin
				nxt.st = st_wait_rel; // [R12]
			end
			st_wait_rel: begin
				// Single-word transfers also finish through state 7
				if (!r.ctl_s2) begin // [R12]
					if (r.dma && r.count != count_reset) begin
						nxt.st = st_grab; // [R13]
						nxt.bus_req = 1'b1;
					end else begin
						nxt.st = st_done; // [R14]
					end
				end
			end
			st_done: begin
				if (r.irq_en) begin
					nxt.irq = 1'b1; // [R15] [R17]
				end
				nxt.dma = 1'b0;
				nxt.st = st_idle; // [R15]
			end
			default: begin
				nxt.st = st_idle;
			end
		endcase
		if (rst_i) begin
			nxt = '0; // [R18]
			nxt.st = st_idle; // [R18]
			nxt.addr = addr_reset;
			nxt.count = count_reset;
		end
		// --------------------------------------------------
		// Registered status outputs
		// --------------------------------------------------
		// Taken from the next value so the flags never lag the state
		nxt.count_nz = (nxt.count != count_reset); // [R05]
		nxt.busy = nxt.avail || (nxt.st != st_idle);
		nxt.trap = in_trap_addr; // [R17]
	end

	always_ff @(posedge core_clk_i) begin
		r <= nxt;
	end

	// --------------------------------------------------
	// Outputs
	// --------------------------------------------------
	assign link.host_in_data = r.out_data;
	assign link.host_word_avail = r.avail;
	assign link.word_taken_pulse = r.taken;
	assign bus_req_o = r.bus_req;
	assign mem_rd_o = r.mem_rd;
	assign proc_addr_bus_o = r.addr; // [R07]
	assign count_nonzero_o = r.count_nz; // [R05]
	assign busy_o = r.busy;
	assign irq_o = r.irq;
	assign trap_addr_o = r.trap; // [R17]
	assign state_o = r.st;
endmodule : pdma_dev
`default_nettype wire

//--- pdma_host.sv
`timescale 1ns/1ps
`default_nettype none
module pdma_host
	import pdma_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	pdma_link_if.host link,
	input wire logic ready_i,
	output logic [data_width-1:0] word_o,
	output logic word_valid_o,
	output logic [1:0] lead_pos_o
);
	typedef enum logic [1:0] {
		h_idle = 2'h0,
		h_ctl = 2'h1,
		h_rel = 2'h2
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic ctl;
		logic [data_width-1:0] word;
		logic valid;
		logic [1:0] lead;
		logic av_s1;
		logic av_s2;
		logic tk_s1;
		logic tk_s2;
	} host_reg_t;

	host_reg_t r, nxt;

	always_comb begin
		nxt = r;
		nxt.av_s1 = link.host_word_avail;
		nxt.av_s2 = r.av_s1;
		nxt.tk_s1 = link.word_taken_pulse;
		nxt.tk_s2 = r.tk_s1;
		nxt.valid = 1'b0;
		case (r.st)
			h_idle: begin
				if (r.av_s2 && ready_i) begin
					nxt.ctl = 1'b1; // [R16]
					nxt.st = h_ctl;
				end
			end
			h_ctl: begin
				// Data is stable while avail is up, so read on taken
				if (r.tk_s2) begin
					nxt.word = link.host_in_data; // [R16]
					nxt.valid = 1'b1;
					nxt.ctl = 1'b0; // [R12]
					if (r.lead != lead_words) begin
						nxt.lead = r.lead + 2'h1; // [R01]
					end
					nxt.st = h_rel;
				end
			end
			h_rel: begin
				if (!r.tk_s2 && !r.av_s2) begin
					nxt.st = h_idle;
				end
			end
			default: begin
				nxt.st = h_idle;
			end
		endcase
		if (rst_i) begin
			nxt = '0;
			nxt.st = h_idle;
			nxt.lead = lead_header;
		end
	end

	always_ff @(posedge core_clk_i) begin
		r <= nxt;
	end

	assign link.host_in_ctl = r.ctl;
	assign word_o = r.word;
	assign word_valid_o = r.valid;
	assign lead_pos_o = r.lead;
endmodule : pdma_host
`default_nettype wire

//--- pdma_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pdma_checker
	import pdma_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [data_width-1:0] host_in_data,
	input wire logic host_word_avail,
	input wire logic word_taken_pulse,
	input wire logic host_in_ctl
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_taken_len;
		$rose(word_taken_pulse) |-> word_taken_pulse[*8] ##1 !word_taken_pulse;
	endproperty
	a_taken_len: assert property (p_taken_len) else $error("taken pulse length");
	property p_taken_cause;
		$rose(word_taken_pulse) |-> host_in_ctl && !host_word_avail;
	endproperty
	a_taken_cause: assert property (p_taken_cause) else $error("taken pulse cause");
	property p_data_stable;
		$past(host_word_avail) && host_word_avail |-> $stable(host_in_data);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved");
	property p_avail_hold;
		host_word_avail && !host_in_ctl |=> host_word_avail;
	endproperty
	a_avail_hold: assert property (p_avail_hold) else $error("avail dropped");
	property p_ctl_ready;
		$rose(host_in_ctl) |-> host_word_avail;
	endproperty
	a_ctl_ready: assert property (p_ctl_ready) else $error("ctl without word");
	property p_release;
		$fell(host_in_ctl) |-> !host_word_avail;
	endproperty
	a_release: assert property (p_release) else $error("early release");
	property p_new_word;
		$rose(host_word_avail) |-> !host_in_ctl;
	endproperty
	a_new_word: assert property (p_new_word) else $error("word before release");
	property p_reset;
		disable iff (1'b0) rst_i |=> !host_word_avail && !word_taken_pulse;
	endproperty
	a_reset: assert property (p_reset) else $error("reset left link busy");
endmodule : pdma_checker
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pdma_pkg::*;
	logic core_clk_i = 1'b0, rst_i = 1'b1, wr_addr_i = 1'b0, wr_count_i = 1'b0;
	logic wr_status_i = 1'b0, wr_data_i = 1'b0, dma_in_go_i = 1'b0, ext_addr_lo_bit_i = 1'b0;
	logic ext_addr_hi_bit_i = 1'b0, in_irq_enable_i = 1'b0, word_avail_bit_i = 1'b0;
	logic bus_grant_i = 1'b0, mem_ack_i = 1'b0, irq_ack_i = 1'b0, ready_i = 1'b0;
	logic [15:0] proc_data_bus_i = 16'h0, mem_rdata_i = 16'h0, trap_addr_o, word_o;
	logic [15:0] exp_q [0:7];
	logic [17:0] proc_addr_bus_o, addr = 18'h0, base = 18'h0;
	logic [2:0] state_o;
	logic [1:0] lead_pos_o;
	logic bus_req_o, mem_rd_o, count_nonzero_o, busy_o, irq_o, word_valid_o;
	integer seed = 32'hca99;
	int num_errors = 0, n_compared = 0, got = 0;
	pdma_link_if link();
	pdma_dev u_pdma_dev(.core_clk_i, .rst_i, .link(link), .proc_data_bus_i, .wr_addr_i,
		.wr_count_i, .wr_status_i, .wr_data_i, .dma_in_go_i, .ext_addr_lo_bit_i,
		.ext_addr_hi_bit_i, .in_irq_enable_i, .word_avail_bit_i, .bus_grant_i, .mem_ack_i,
		.mem_rdata_i, .irq_ack_i, .bus_req_o, .mem_rd_o, .proc_addr_bus_o, .count_nonzero_o,
		.busy_o, .irq_o, .trap_addr_o, .state_o);
	pdma_host u_pdma_host(.core_clk_i, .rst_i, .link(link), .ready_i, .word_o, .word_valid_o,
		.lead_pos_o);
	pdma_checker u_pdma_checker(.core_clk_i, .rst_i, .host_in_data(link.host_in_data),
		.host_word_avail(link.host_word_avail), .word_taken_pulse(link.word_taken_pulse),
		.host_in_ctl(link.host_in_ctl));
	always #10 core_clk_i = ~core_clk_i;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	function automatic logic [15:0] mem_word(input logic [17:0] a);
		return a[15:0] ^ 16'h5a5a;
	endfunction : mem_word
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	// Status bits held after the strobe; only the strobe edge matters
	task automatic strobe(input logic [3:0] w, input logic [4:0] st, input logic [15:0] d);
		{wr_data_i, wr_addr_i, wr_count_i, wr_status_i} <= w;
		{dma_in_go_i, ext_addr_hi_bit_i, ext_addr_lo_bit_i, in_irq_enable_i, word_avail_bit_i} <= st;
		proc_data_bus_i <= d;
		@(posedge core_clk_i);
		{wr_data_i, wr_addr_i, wr_count_i, wr_status_i} <= 4'h0;
		@(posedge core_clk_i);
	endtask : strobe
	task automatic wait_for(input int t);
		int i;
		for (i = 0; i < 3000 && !(got == t && state_o === 3'h0); i++) @(posedge core_clk_i);
		check("done", i < 3000, 1'b1);
	endtask : wait_for
	// ----------------------------------------
	// Memory, grant and host readiness
	// ----------------------------------------
	// Grant and readiness are random so the sequencer sees stalls
	always @(posedge core_clk_i) begin
		bus_grant_i <= bus_req_o & 1'($random(seed));
		ready_i <= 1'($random(seed));
		mem_ack_i <= 1'b0;
		if (mem_rd_o === 1'b1 && !mem_ack_i && state_o === 3'h2) begin
			check("addr", proc_addr_bus_o, addr);
			mem_ack_i <= 1'b1;
			mem_rdata_i <= mem_word(addr);
			addr <= addr + 18'h2;
		end
		if (word_valid_o === 1'b1 && got < 8) begin
			check("word", word_o, exp_q[got]);
			got <= got + 1;
		end
		if (rst_i) begin
			got <= 0;
			addr <= base;
		end
	end
	initial begin
		repeat (60000) @(posedge core_clk_i);
		num_errors++;
		test_done;
	end
	// ----------------------------------------
	// Messages
	// ----------------------------------------
	initial begin
		int k, j, n;
		logic [17:0] a;
		for (k = 0; k < 6; k++) begin
			n = k == 0 ? 1 : {$random(seed)} % 5 + 1;
			a = 18'($random(seed)) & 18'h3fffe;
			base = a;
			exp_q[0] = 16'($random(seed));
			exp_q[1] = a[15:0];
			exp_q[2] = 16'(n);
			for (j = 0; j < n; j++) exp_q[3 + j] = mem_word(a + 18'(2 * j));
			// From the second message on, offer a word, then reset while it is still pending
			if (k != 0) begin
				strobe(4'h1, 5'h01, 16'h0);
				check("avail", link.host_word_avail, 1'b1);
			end
			rst_i <= 1'b1;
			repeat (3) @(posedge core_clk_i);
			rst_i <= 1'b0;
			check("avail reset", link.host_word_avail, 1'b0);
			check("bus reset", bus_req_o, 1'b0);
			check("state reset", state_o, 3'h0);
			@(posedge core_clk_i);
			for (j = 0; j < 3; j++) begin
				strobe(4'h8, 5'h00, exp_q[j]);
				strobe(4'h1, 5'h01, 16'h0);
				wait_for(j + 1);
				check("lead", lead_pos_o, j + 1);
			end
			strobe(4'h4, 5'h00, a[15:0]);
			strobe(4'h1, {1'b0, a[17:16], 2'b00}, 16'h0);
			strobe(4'h2, {1'b0, a[17:16], 2'b00}, 16'(-n));
			check("nonzero", count_nonzero_o, 1'b1);
			strobe(4'h1, {1'b1, a[17:16], k[0], 1'b0}, 16'h0);
			check("state go", state_o, 3'h1);
			check("bus req", bus_req_o, 1'b1);
			check("busy", busy_o, 1'b1);
			wait_for(n + 3);
			check("irq", irq_o, k[0]);
			check("count", count_nonzero_o, 1'b0);
			check("idle", busy_o, 1'b0);
			check("lead end", lead_pos_o, 3);
			check("trap", trap_addr_o, 16'h0050);
			irq_ack_i <= 1'b1;
			@(posedge core_clk_i);
			irq_ack_i <= 1'b0;
			@(posedge core_clk_i);
			check("irq clear", irq_o, 1'b0);
		end
		test_done;
	end
endmodule : testbench
`default_nettype wire
